// file: bench/esf_host_model.sv
`timescale 1ns/1ns
module esf_host_model (
    input wire logic clk_sys,
    output logic read_detector_source_two,
    output logic read_orientation_state,
    output logic read_system_mode
);
    initial
    begin
        read_detector_source_two = 1'b0;
        read_orientation_state = 1'b0;
        read_system_mode = 1'b0;
    end

    // Host register read, one strobe cycle; 0 source two, 1 orientation, 2 mode
    task automatic rd(input int which);
        @(negedge clk_sys);
        read_detector_source_two = (which == 0);
        read_orientation_state = (which == 1);
        read_system_mode = (which == 2);
        @(negedge clk_sys);
        read_detector_source_two = 1'b0;
        read_orientation_state = 1'b0;
        read_system_mode = 1'b0;
    endtask
endmodule

// file: bench/tb.sv
`timescale 1ns/1ns
`define CHK(nm, ex, got) \
    begin \
        n_checks++; \
        if ((got) !== (ex)) \
        begin \
            errors++; \
            $display("MISMATCH %s exp %h got %h", nm, ex, got); \
        end \
    end
module tb;
    logic clk_sys, rst, cond, latch, fresh, chg, tick, evt, en, flex, sleep_r, wla;
    logic [7:0] lim_lo, lim_hi, summary;
    logic [3:0] ap, ao, ad, ai;
    logic [3:0] cfg [8];
    wire rd2, rdo, rdm;
    int errors, n_checks, cyc;

    esf_host_model host_u (
        .clk_sys(clk_sys),
        .read_detector_source_two(rd2),
        .read_orientation_state(rdo),
        .read_system_mode(rdm)
    );

    esf_event_status dut_u (
        .clk_sys(clk_sys),
        .rst(rst),
        .within_limits_condition(cond),
        .within_limits_latch_enable(latch),
        .read_detector_source_two(rd2),
        .fresh_orientation_bit(fresh),
        .orientation_changed(chg),
        .read_orientation_state(rdo),
        .read_system_mode(rdm),
        .odr_tick(tick),
        .configured_event(evt),
        .inactivity_limit_low(lim_lo),
        .inactivity_limit_high(lim_hi),
        .auto_dormant_irq_enable(en),
        .flexible_mode(flex),
        .dormant_power_setting(cfg[0]),
        .active_power_setting(cfg[1]),
        .dormant_odr(cfg[2]),
        .active_odr(cfg[3]),
        .dormant_decimation(cfg[4]),
        .active_decimation(cfg[5]),
        .dormant_idle(cfg[6]),
        .active_idle(cfg[7]),
        .interrupt_event_summary(summary),
        .within_limits_event_active(wla),
        .system_mode_sleep_r(sleep_r),
        .applied_power_r(ap),
        .applied_odr_r(ao),
        .applied_decimation_r(ad),
        .applied_idle_r(ai)
    );

    task automatic test_done;
        $display("TB: checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // One pulse on an input, one cycle wide
    task automatic pulse(ref logic s);
        @(negedge clk_sys);
        s = 1'b1;
        @(negedge clk_sys);
        s = 1'b0;
    endtask

    // Mode change may take one or two cycles past the cause
    task automatic wait_mode(input logic v);
        for (int i = 0; i < 6 && sleep_r !== v; i++)
            @(negedge clk_sys);
    endtask

    task automatic t_latched;
        @(negedge clk_sys);
        latch = 1'b1;
        cond = 1'b1;
        @(negedge clk_sys);
        cond = 1'b0;
        repeat (3) @(negedge clk_sys);
        `CHK("wt latched", 1'b1, summary[esf_pkg::WT_BIT])
        `CHK("wt source", 1'b1, wla)
        host_u.rd(0);
        `CHK("wt cleared", 1'b0, summary[esf_pkg::WT_BIT])
    endtask

    task automatic t_free;
        @(negedge clk_sys);
        latch = 1'b0;
        cond = 1'b1;
        @(negedge clk_sys);
        `CHK("wt follow", 1'b1, summary[esf_pkg::WT_BIT])
        cond = 1'b0;
        @(negedge clk_sys);
        `CHK("wt auto clr", 1'b0, summary[esf_pkg::WT_BIT])
        `CHK("wt src clr", 1'b0, wla)
    endtask

    task automatic t_orient;
        @(negedge clk_sys);
        fresh = 1'b1;
        @(negedge clk_sys);
        `CHK("orient lone", 1'b0, summary[esf_pkg::ORIENT_BIT])
        chg = 1'b1;
        @(negedge clk_sys);
        fresh = 1'b0;
        chg = 1'b0;
        `CHK("orient set", 1'b1, summary[esf_pkg::ORIENT_BIT])
        host_u.rd(1);
        `CHK("orient clr", 1'b0, summary[esf_pkg::ORIENT_BIT])
    endtask

    // Idle limit of two ticks; settings distinct per pass
    task automatic t_sleep(input logic f);
        for (int i = 0; i < 8; i++)
            cfg[i] = {f, 3'(i)};
        flex = f;
        lim_hi = 8'h00;
        lim_lo = 8'h02;
        en = 1'b1;
        pulse(tick);
        pulse(evt);
        pulse(tick);
        repeat (4) @(negedge clk_sys);
        `CHK("no early sleep", 1'b0, sleep_r)
        pulse(tick);
        wait_mode(1'b1);
        `CHK("sleep", 1'b1, sleep_r)
        `CHK("flag w2s", 1'b1, summary[esf_pkg::ASLP_BIT])
        `CHK("pwr sleep", cfg[0], ap)
        `CHK("odr sleep", f ? cfg[3] : cfg[2], ao)
        `CHK("dec sleep", f ? cfg[4] : cfg[5], ad)
        `CHK("idle sleep", f ? cfg[6] : cfg[7], ai)
        host_u.rd(2);
        `CHK("flag clr", 1'b0, summary[esf_pkg::ASLP_BIT])
        `CHK("mode kept", 1'b1, sleep_r)
        pulse(evt);
        wait_mode(1'b0);
        `CHK("wake", 1'b0, sleep_r)
        `CHK("flag s2w", 1'b1, summary[esf_pkg::ASLP_BIT])
        `CHK("pwr wake", cfg[1], ap)
        `CHK("odr wake", cfg[3], ao)
        `CHK("dec wake", cfg[5], ad)
        `CHK("idle wake", cfg[7], ai)
        host_u.rd(2);
        `CHK("flag clr s2w", 1'b0, summary[esf_pkg::ASLP_BIT])
    endtask

    // Disabled with a limit of one, then armed, asleep and disarmed by a zero limit
    task automatic t_disarm;
        for (int k = 0; k < 2; k++)
        begin
            en = (k == 1);
            lim_lo = 8'h01;
            repeat (3) pulse(tick);
            repeat (3) @(negedge clk_sys);
            `CHK("disarm sleep", (k == 1), sleep_r)
            lim_lo = 8'h00;
            repeat (3) @(negedge clk_sys);
            `CHK("disarm mode", 1'b0, sleep_r)
            `CHK("disarm flag", 1'b0, summary[esf_pkg::ASLP_BIT])
        end
    endtask

    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Hang guard, well above the hundred or fewer cycles the run needs
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            errors++;
            test_done();
        end
    end

    initial
    begin
        {cond, latch, fresh, chg, tick, evt, en, flex} = '0;
        lim_lo = 8'h00;
        lim_hi = 8'h00;
        for (int i = 0; i < 8; i++)
            cfg[i] = 4'h0;
        rst = 1'b1;
        repeat (2) @(negedge clk_sys);
        rst = 1'b0;
        `CHK("summary rst", esf_pkg::SUMMARY_RESET, summary)
        `CHK("mode rst", 1'b0, sleep_r)
        t_latched();
        t_free();
        t_orient();
        t_sleep(1'b0);
        t_sleep(1'b1);
        t_disarm();
        test_done();
    end
endmodule

// file: rtl/esf_event_status.sv
`timescale 1ns/1ns
// Behaviour
// [RULE1] Summary bit 3 always shows the within-limits event flag of detector source two.
// [RULE2] With latching enabled, bit 3 clears only when detector source two is read.
// [RULE3] With latching off, bit 3 drops by itself once the within-limits condition ends.
// [RULE4] Bit 2 sets when a fresh orientation is flagged with a real change, else stays 0.
// [RULE5] Reading the orientation state register clears bit 2.
// [RULE6] Bit 1 sets on any WAKE/SLEEP transition in either direction.
// [RULE7] The system mode register shows the direction of the latest transition.
// [RULE8] Idle data periods are counted and reaching the 16-bit limit sends WAKE to SLEEP.
// [RULE9] Entering SLEEP applies the dormant power, rate or decimation and idle settings; the code applies dormant idle only with flexible_mode set.
// [RULE10] Any configured event during SLEEP returns to WAKE with the active settings.
// [RULE11] Reading the system mode register clears bit 1.
// [RULE12] Auto wake/sleep and its flag work only with limit at least 1 and enable set.
// [RULE13] The idle count restarts on any event in WAKE and on every return to WAKE.
module esf_event_status #(
    parameter int LIMIT_W = esf_pkg::LIMIT_W_DOC,
    parameter int SET_W = esf_pkg::SET_W_DOC
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic within_limits_condition,
    input wire logic within_limits_latch_enable,
    input wire logic read_detector_source_two,
    input wire logic fresh_orientation_bit,
    input wire logic orientation_changed,
    input wire logic read_orientation_state,
    input wire logic read_system_mode,
    input wire logic odr_tick,
    input wire logic configured_event,
    input wire logic [esf_pkg::HALF_W-1:0] inactivity_limit_low,
    input wire logic [esf_pkg::HALF_W-1:0] inactivity_limit_high,
    input wire logic auto_dormant_irq_enable,
    input wire logic flexible_mode,
    input wire logic [SET_W-1:0] dormant_power_setting,
    input wire logic [SET_W-1:0] active_power_setting,
    input wire logic [SET_W-1:0] dormant_odr,
    input wire logic [SET_W-1:0] active_odr,
    input wire logic [SET_W-1:0] dormant_decimation,
    input wire logic [SET_W-1:0] active_decimation,
    input wire logic [SET_W-1:0] dormant_idle,
    input wire logic [SET_W-1:0] active_idle,
    output logic [7:0] interrupt_event_summary,
    output logic within_limits_event_active,
    output logic system_mode_sleep_r,
    output logic [SET_W-1:0] applied_power_r,
    output logic [SET_W-1:0] applied_odr_r,
    output logic [SET_W-1:0] applied_decimation_r,
    output logic [SET_W-1:0] applied_idle_r
);
    esf_pkg::esf_mode_t mode_r;
    esf_pkg::esf_mode_t mode_nxt;
    logic wt_r;
    logic orient_r;
    logic aslp_r;
    logic armed;
    logic go_sleep;
    logic go_wake;
    logic trans;
    logic sleep_nxt;

    esf_inact_if #(.LIMIT_W(LIMIT_W)) inact ();

    initial
    begin
        if (LIMIT_W != 2 * esf_pkg::HALF_W || SET_W < 1)
        begin
            $error("unsupported parameter values");
        end
    end

    // [RULE12] Arm only when enabled
    assign armed = auto_dormant_irq_enable
        && ({inactivity_limit_high, inactivity_limit_low} != '0);

    assign inact.tick = odr_tick;
    assign inact.armed = armed;
    assign inact.limit = {inactivity_limit_high, inactivity_limit_low};
    // [RULE13] Restart on event
    assign inact.restart = configured_event || (mode_r == esf_pkg::ESF_SLEEP);

    esf_inact_counter #(.LIMIT_W(LIMIT_W)) u_counter (
        .clk_sys(clk_sys),
        .rst(rst),
        .link(inact.cnt)
    );

    // Activity in the expiry cycle wins, so a fresh event never sends us to sleep
    assign go_sleep = (mode_r == esf_pkg::ESF_WAKE) && armed && inact.expire
        && !configured_event;
    assign go_wake = (mode_r == esf_pkg::ESF_SLEEP) && armed && configured_event;
    assign trans = go_sleep || go_wake;

    // [RULE8] Inactivity sends to sleep
    // [RULE10] Event returns to wake
    always_comb
    begin
        mode_nxt = mode_r;
        unique case (mode_r)
            esf_pkg::ESF_WAKE:
            begin
                if (go_sleep)
                begin
                    mode_nxt = esf_pkg::ESF_SLEEP;
                end
            end
            esf_pkg::ESF_SLEEP:
            begin
                // Disarming drops back to wake quietly, without a flag
                if (go_wake || !armed)
                begin
                    mode_nxt = esf_pkg::ESF_WAKE;
                end
            end
        endcase
    end

    assign sleep_nxt = (mode_nxt == esf_pkg::ESF_SLEEP);

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            mode_r <= esf_pkg::ESF_WAKE;
        end
        else
        begin
            mode_r <= mode_nxt;
        end
    end

    // [RULE7] Transition direction
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            system_mode_sleep_r <= esf_pkg::FLAG_RESET;
        end
        else
        begin
            system_mode_sleep_r <= sleep_nxt;
        end
    end

    // [RULE9] Dormant settings apply
    // [RULE10] Active settings apply
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            applied_power_r <= '0;
            applied_odr_r <= '0;
            applied_decimation_r <= '0;
            applied_idle_r <= '0;
        end
        else
        begin
            applied_power_r <= sleep_nxt ? dormant_power_setting : active_power_setting;
            applied_odr_r <= (sleep_nxt && !flexible_mode) ? dormant_odr : active_odr;
            applied_decimation_r <= (sleep_nxt && flexible_mode) ? dormant_decimation
                : active_decimation;
            applied_idle_r <= (sleep_nxt && flexible_mode) ? dormant_idle : active_idle;
        end
    end

    // [RULE2] Latched clear on read
    // [RULE3] Unlatched follows condition
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            wt_r <= esf_pkg::FLAG_RESET;
        end
        else if (!within_limits_latch_enable)
        begin
            wt_r <= within_limits_condition;
        end
        else if (within_limits_condition)
        begin
            wt_r <= 1'b1;
        end
        else if (read_detector_source_two)
        begin
            wt_r <= 1'b0;
        end
    end

    // [RULE4] Orientation change sets
    // [RULE5] Read clears, set wins
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            orient_r <= esf_pkg::FLAG_RESET;
        end
        else if (fresh_orientation_bit && orientation_changed)
        begin
            orient_r <= 1'b1;
        end
        else if (read_orientation_state)
        begin
            orient_r <= 1'b0;
        end
    end

    // [RULE6] Transition sets flag
    // [RULE11] Mode read clears
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            aslp_r <= esf_pkg::FLAG_RESET;
        end
        else if (trans)
        begin
            aslp_r <= 1'b1;
        end
        else if (read_system_mode || !armed)
        begin
            aslp_r <= 1'b0;
        end
    end

    // [RULE1] Summary mirrors flags
    always_comb
    begin
        interrupt_event_summary = esf_pkg::SUMMARY_RESET;
        interrupt_event_summary[esf_pkg::WT_BIT] = wt_r;
        interrupt_event_summary[esf_pkg::ORIENT_BIT] = orient_r;
        interrupt_event_summary[esf_pkg::ASLP_BIT] = aslp_r;
    end
    assign within_limits_event_active = wt_r;

    AST_WT_MIRROR: assert property (@(posedge clk_sys) disable iff (rst) // [RULE1]
        within_limits_condition
        |=> interrupt_event_summary[esf_pkg::WT_BIT] && within_limits_event_active)
        else $error("bit 3 or source flag not set by event");
    AST_WT_LATCH_HOLD: assert property (@(posedge clk_sys) disable iff (rst) // [RULE2]
        within_limits_latch_enable && wt_r && !read_detector_source_two |=> wt_r)
        else $error("latched flag lost without read");
    AST_WT_LATCH_CLEAR: assert property (@(posedge clk_sys) disable iff (rst) // [RULE2]
        within_limits_latch_enable && read_detector_source_two && !within_limits_condition
        |=> !interrupt_event_summary[esf_pkg::WT_BIT])
        else $error("latched flag not cleared by read");
    AST_WT_FOLLOW: assert property (@(posedge clk_sys) disable iff (rst) // [RULE3]
        !within_limits_latch_enable |=> wt_r == $past(within_limits_condition))
        else $error("unlatched flag not following condition");
    AST_ORIENT_SET: assert property (@(posedge clk_sys) disable iff (rst) // [RULE4]
        fresh_orientation_bit && orientation_changed
        |=> interrupt_event_summary[esf_pkg::ORIENT_BIT])
        else $error("orientation flag not set");
    AST_ORIENT_CLEAR: assert property (@(posedge clk_sys) disable iff (rst) // [RULE5]
        read_orientation_state && !(fresh_orientation_bit && orientation_changed)
        |=> !orient_r)
        else $error("orientation flag not cleared");
    AST_ASLP_SET: assert property (@(posedge clk_sys) disable iff (rst) // [RULE6]
        trans |=> aslp_r && (system_mode_sleep_r != $past(system_mode_sleep_r)))
        else $error("transition flag or mode wrong");
    AST_DIRECTION: assert property (@(posedge clk_sys) disable iff (rst) // [RULE7]
        go_sleep |=> system_mode_sleep_r)
        else $error("sleep direction not shown");
    AST_DORMANT_RATE: assert property (@(posedge clk_sys) disable iff (rst) // [RULE9]
        system_mode_sleep_r && !$past(flexible_mode) |-> applied_odr_r == $past(dormant_odr))
        else $error("dormant rate not applied");
    AST_WAKE_ON_EVENT: assert property (@(posedge clk_sys) disable iff (rst) // [RULE10]
        system_mode_sleep_r && armed && configured_event
        |=> !system_mode_sleep_r && applied_power_r == $past(active_power_setting))
        else $error("no return to wake");
    AST_ASLP_CLEAR: assert property (@(posedge clk_sys) disable iff (rst) // [RULE11]
        read_system_mode && !trans |=> !aslp_r)
        else $error("transition flag not cleared");
    AST_DISARMED: assert property (@(posedge clk_sys) disable iff (rst) // [RULE12]
        !armed |=> !system_mode_sleep_r && !aslp_r)
        else $error("auto sleep active while disarmed");

    COV_SLEEP: cover property (@(posedge clk_sys) disable iff (rst) go_sleep);
    COV_WAKE: cover property (@(posedge clk_sys) disable iff (rst) go_wake);
    COV_WT_LATCHED_READ: cover property (@(posedge clk_sys) disable iff (rst)
        wt_r && within_limits_latch_enable ##1 read_detector_source_two);
    COV_ORIENT: cover property (@(posedge clk_sys) disable iff (rst)
        orient_r ##1 read_orientation_state);
endmodule

// file: rtl/esf_inact_counter.sv
`timescale 1ns/1ns
module esf_inact_counter #(
    parameter int LIMIT_W = 16
) (
    input wire logic clk_sys,
    input wire logic rst,
    esf_inact_if.cnt link
);
    logic [LIMIT_W-1:0] count_r;
    logic expire_r;
    logic at_limit;

    initial
    begin
        if (LIMIT_W < 2 || LIMIT_W > 32)
        begin
            $error("LIMIT_W out of range");
        end
    end

    assign at_limit = (count_r == link.limit - LIMIT_W'(1));
    assign link.expire = expire_r;

    // [RULE8] Count idle data periods
    // [RULE13] Restart on activity
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            count_r <= '0;
        end
        else if (link.restart || !link.armed)
        begin
            count_r <= '0;
        end
        else if (link.tick)
        begin
            count_r <= at_limit ? '0 : count_r + LIMIT_W'(1);
        end
    end

    // [RULE8] Expiry pulse at limit
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            expire_r <= 1'b0;
        end
        else
        begin
            expire_r <= link.tick && link.armed && !link.restart && at_limit;
        end
    end

    AST_EXPIRE_AT_LIMIT: assert property (@(posedge clk_sys) disable iff (rst)
        link.tick && link.armed && !link.restart && at_limit |=> expire_r) // [RULE8]
        else $error("inactivity expiry missed");
    AST_RESTART_CLEARS: assert property (@(posedge clk_sys) disable iff (rst)
        link.restart |=> count_r == '0) // [RULE13]
        else $error("counter not restarted");
endmodule

// file: shared/esf_inact_if.sv
`timescale 1ns/1ns
interface esf_inact_if #(
    parameter int LIMIT_W = 16
);
    logic tick;
    logic restart;
    logic armed;
    logic [LIMIT_W-1:0] limit;
    logic expire;

    modport ctl (
        output tick,
        output restart,
        output armed,
        output limit,
        input expire
    );
    modport cnt (
        input tick,
        input restart,
        input armed,
        input limit,
        output expire
    );
endinterface

// file: shared/esf_pkg.sv
package esf_pkg;
    localparam logic [7:0] SUMMARY_OFFSET = 8'h00;
    localparam int WT_BIT = 3;
    localparam int ORIENT_BIT = 2;
    localparam int ASLP_BIT = 1;
    localparam logic [7:0] SUMMARY_RESET = 8'h00;
    localparam logic FLAG_RESET = 1'b0;
    localparam int LIMIT_W_DOC = 16;
    localparam int SET_W_DOC = 4;
    localparam int HALF_W = 8;

    typedef enum logic {
        ESF_WAKE,
        ESF_SLEEP
    } esf_mode_t;
endpackage
